/* File: design/ckpm_top.sv */
// Clock source selection, multiplier sequencing, clock dividers and power modes.
// Assumes an AHB-Lite master, a clockless wake interrupt and tick strobes per oscillator.
//
// Operation
// RULE1 - Software selects internal RC, main crystal or real-time oscillator as source.
// RULE2 - Reset selects internal RC; it stays until software changes the source.
// RULE3 - Input divider N is programmable from 1 to 256.
// RULE4 - Multiplier M is 1 to 32768; software keeps core within 275-550 MHz.
// RULE5 - Reset or power-down forces multiplier off and bypassed; only software re-enables.
// RULE6 - Software configures, enables, waits for lock, then connects the multiplier.
// RULE7 - Processor clock is the multiplier input unless multiplier active and connected.
// RULE8 - Every peripheral has its own clock divider and clock gate.
// RULE9 - Wake from power-down and power-up run from the internal RC oscillator.
// RULE10 - Crystal is not used as processor clock until its wake-up timer expires.
// RULE11 - Idle stops the processor until interrupt or reset; peripheral clocks keep running.
// RULE12 - Sleep stops clocks, retains state, gates RC output, keeps RC powered.
// RULE13 - Sleep entry turns off and disconnects multiplier and clears CPU/USB dividers.
// RULE14 - Sleep exits only on reset or clockless interrupt; flash stays powered.
// RULE15 - Sleep wake resumes after 4 RC cycles or 4096 crystal cycles.
// RULE16 - After wake, software reprograms the multiplier and dividers.
// RULE17 - Power-down also shuts off the RC oscillator and flash.
// RULE18 - Power-down wake: 60 us RC start, 4 RC cycles, flash waits 100 us.
// RULE19 - Deep power-down removes logic power; leaving it is a full reset.
// RULE20 - Deep power-down wakes only on real-time alarm or external reset.
// RULE21 - Battery RAM keeps its contents through deep power-down.
// RULE22 - Real-time alarm is driven out to let external hardware restore power.
// RULE23 - Flash wake counter counts 400 RC periods and then raises flash ready.
// RULE24 - Mode entry only on software request; request clears when wake completes.
`timescale 1ns/10ps
module ckpm_top
  import ckpm_pkg::*;
(
  input  wire logic                  clock,
  input  wire logic                  rst,
  input  wire logic                  hsel,
  input  wire logic [31:0]           haddr,
  input  wire logic [1:0]            htrans,
  input  wire logic                  hwrite,
  input  wire logic [2:0]            hsize,
  input  wire logic [31:0]           hwdata,
  input  wire logic                  hready,
  output logic      [31:0]           hrdata,
  output logic                       hreadyout,
  output logic                       hresp,
  input  wire logic                  irc_tick,
  input  wire logic                  main_tick,
  input  wire logic                  rtc_tick,
  input  wire logic                  mult_tick,
  input  wire logic                  mult_lock,
  input  wire logic                  any_irq,
  input  wire logic                  wake_irq,
  input  wire logic                  rtc_alarm,
  output logic      [1:0]            multiplier_input_clock_sel,
  output logic                       processor_clock_en,
  output logic                       usb_clock_en,
  output logic      [NUM_PERIPH-1:0] periph_clock_en,
  output logic                       cpu_halt,
  output logic                       irc_power_en,
  output logic                       irc_out_en,
  output logic                       main_osc_en,
  output logic                       flash_power_en,
  output logic                       flash_ready,
  output logic                       regulator_en,
  output logic                       mult_power_en,
  output logic                       mult_bypass,
  output logic      [14:0]           mult_m_val,
  output logic      [7:0]            mult_n_val,
  output logic                       chip_reset_req,
  output logic                       alarm_out
);

  ckpm_state_t                 state_r;
  logic [3:0]                  mode_req_r;
  logic [1:0]                  src_sel_r;
  logic [14:0]                 m_r;
  logic [7:0]                  n_r;
  logic                        mul_en_r, mul_con_r, main_en_r;
  logic [7:0]                  cpudiv_r, cdiv_cnt_r;
  logic [3:0]                  usbdiv_r, udiv_cnt_r;
  logic [NUM_PERIPH-1:0]       pgate_r;
  logic [2*NUM_PERIPH-1:0]     pdiv_r;
  logic [12:0]                 wcnt_r, mstab_cnt_r, wake_target;
  logic [9:0]                  ircs_cnt_r;
  logic [8:0]                  fcnt_r;
  logic                        wake_main_r, main_stable, mult_active, wake_tick, wake_done;
  logic [1:0]                  eff_src;
  logic                        src_tick, base_tick, clocks_on, enter_lowpwr;
  logic                        acc_ok, wr_pend_r;
  logic [7:0]                  waddr_r;
  logic [31:0]                 rd_nxt;
  logic [31:0]                 bram [BRAM_WORDS];
  logic [2:0]                  pcnt_r [NUM_PERIPH];

  // ----------------------------------------------------------------
  // AHB-Lite slave: zero wait, always OKAY
  // ----------------------------------------------------------------
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign acc_ok    = hsel && htrans[1] && hready;

  always_comb begin
    rd_nxt = 32'h0;
    case (haddr[7:0])
      A_SRCSEL:  rd_nxt = {30'h0, src_sel_r};
      A_MULCFG:  rd_nxt = {8'h0, n_r, 1'b0, m_r};
      A_MULCTL:  rd_nxt = {30'h0, mul_con_r, mul_en_r};
      A_MULSTAT: rd_nxt = {5'h0, mult_lock, mul_con_r, mul_en_r, n_r, 1'b0, m_r};
      A_CPUDIV:  rd_nxt = {24'h0, cpudiv_r};
      A_USBDIV:  rd_nxt = {28'h0, usbdiv_r};
      A_PGATE:   rd_nxt = {24'h0, pgate_r};
      A_PDIV:    rd_nxt = {16'h0, pdiv_r};
      A_PWRMODE: rd_nxt = {28'h0, mode_req_r};
      A_OSCCTL:  rd_nxt = {29'h0, flash_ready, main_stable, main_en_r};
      default: begin
        if (haddr[7:6] == A_BRAM[7:6])
          rd_nxt = bram[haddr[5:2]];
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      wr_pend_r <= 1'b0;
      waddr_r   <= 8'h0;
      hrdata    <= 32'h0;
    end else begin
      wr_pend_r <= acc_ok && hwrite;
      if (acc_ok) begin
        waddr_r <= haddr[7:0];
        if (!hwrite)
          hrdata <= rd_nxt;
      end
    end
  end

  // Battery RAM has no reset: it lives on the backup supply
  always_ff @(posedge clock) begin
    if (wr_pend_r && waddr_r[7:6] == A_BRAM[7:6])
      bram[waddr_r[5:2]] <= hwdata;  // RULE21
  end

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  assign enter_lowpwr = wr_pend_r && waddr_r == A_PWRMODE && state_r == S_RUN &&
                        (hwdata[3:0] == MODE_SLEEP || hwdata[3:0] == MODE_PDOWN);

  always_ff @(posedge clock) begin
    if (rst) begin
      src_sel_r <= SRC_IRC;  // RULE2
      m_r       <= 15'h0;
      n_r       <= 8'h0;
      mul_en_r  <= 1'b0;  // RULE5
      mul_con_r <= 1'b0;
      cpudiv_r  <= 8'h0;
      usbdiv_r  <= 4'h0;
      pgate_r   <= PGATE_RST;
      pdiv_r    <= 16'h0;
      main_en_r <= 1'b0;
    end else if (enter_lowpwr) begin
      mul_en_r  <= 1'b0;  // RULE5 RULE13
      mul_con_r <= 1'b0;
      cpudiv_r  <= 8'h0;  // RULE13
      usbdiv_r  <= 4'h0;
      if (hwdata[3:0] == MODE_PDOWN)
        src_sel_r <= SRC_IRC;  // RULE9
    end else if (wr_pend_r) begin
      case (waddr_r)
        A_SRCSEL: if (hwdata[1:0] != 2'h3) src_sel_r <= hwdata[1:0];  // RULE1
        A_MULCFG: begin
          m_r <= hwdata[14:0];  // RULE4
          n_r <= hwdata[MUL_N_LSB +: 8];  // RULE3
        end
        A_MULCTL: begin
          mul_en_r  <= hwdata[0];
          mul_con_r <= hwdata[1];
        end
        A_CPUDIV: cpudiv_r  <= hwdata[7:0];
        A_USBDIV: usbdiv_r  <= hwdata[3:0];
        A_PGATE:  pgate_r   <= hwdata[7:0];  // RULE8
        A_PDIV:   pdiv_r    <= hwdata[15:0];  // RULE8
        A_OSCCTL: main_en_r <= hwdata[0];
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Source selection and crystal wake-up timer
  // ----------------------------------------------------------------
  assign main_stable = mstab_cnt_r == 13'(MAIN_STABLE_TICKS);
  assign eff_src     = (src_sel_r == SRC_MAIN && !main_stable) ? SRC_IRC : src_sel_r;  // RULE10
  assign multiplier_input_clock_sel = eff_src;
  assign src_tick    = (eff_src == SRC_MAIN) ? main_tick :
                       (eff_src == SRC_RTC)  ? rtc_tick  : irc_tick;  // RULE1
  assign mult_active = mul_en_r && mul_con_r && mult_lock;  // RULE6
  assign base_tick   = mult_active ? mult_tick : src_tick;  // RULE7
  assign main_osc_en = main_en_r && (clocks_on || (state_r == S_WAKE && wake_main_r));

  always_ff @(posedge clock) begin
    if (rst || !main_osc_en)
      mstab_cnt_r <= 13'h0;
    else if (main_tick && !main_stable)
      mstab_cnt_r <= mstab_cnt_r + 13'h1;  // RULE10
  end

  // ----------------------------------------------------------------
  // Power-mode sequencer
  // ----------------------------------------------------------------
  assign clocks_on   = state_r == S_RUN || state_r == S_IDLE;
  assign wake_target = wake_main_r ? 13'(SLEEP_WAKE_MAIN - 1) : 13'(SLEEP_WAKE_IRC - 1);
  assign wake_tick   = wake_main_r ? main_tick : irc_tick;
  assign wake_done   = state_r == S_WAKE && wake_tick && wcnt_r == wake_target;

  always_ff @(posedge clock) begin
    if (rst) begin
      state_r     <= S_RUN;
      mode_req_r  <= 4'h0;
      wcnt_r      <= 13'h0;
      ircs_cnt_r  <= 10'h0;
      wake_main_r <= 1'b0;
    end else begin
      case (state_r)
        S_RUN: begin
          if (wr_pend_r && waddr_r == A_PWRMODE) begin  // RULE24
            mode_req_r <= hwdata[3:0];
            case (hwdata[3:0])
              MODE_IDLE:  state_r <= S_IDLE;
              MODE_SLEEP: state_r <= S_SLEEP;
              MODE_PDOWN: state_r <= S_PDOWN;
              MODE_DPD:   state_r <= S_DPD;
              default:    mode_req_r <= 4'h0;
            endcase
          end
        end
        S_IDLE: if (any_irq || wake_irq) begin  // RULE11
          state_r    <= S_RUN;
          mode_req_r <= 4'h0;
        end
        S_SLEEP: if (wake_irq) begin  // RULE14
          state_r     <= S_WAKE;
          wcnt_r      <= 13'h0;
          wake_main_r <= src_sel_r == SRC_MAIN;  // RULE15
        end
        S_PDOWN: if (wake_irq) begin
          state_r     <= S_IRCSTART;
          ircs_cnt_r  <= 10'h0;
          wake_main_r <= 1'b0;  // RULE9
        end
        S_IRCSTART: begin
          if (ircs_cnt_r == 10'(IRC_START_CYC - 1)) begin  // RULE18
            state_r <= S_WAKE;
            wcnt_r  <= 13'h0;
          end else
            ircs_cnt_r <= ircs_cnt_r + 10'h1;
        end
        S_WAKE: begin
          if (wake_done) begin  // RULE15 RULE18
            state_r    <= S_RUN;
            mode_req_r <= 4'h0;  // RULE24
          end else if (wake_tick)
            wcnt_r <= wcnt_r + 13'h1;
        end
        S_DPD: ;  // RULE19 RULE20
        default: state_r <= S_RUN;
      endcase
    end
  end

  // Deep power-down leaves only through a chip reset
  always_ff @(posedge clock) begin
    if (rst) begin
      chip_reset_req <= 1'b0;
      alarm_out      <= 1'b0;
    end else begin
      chip_reset_req <= state_r == S_DPD && rtc_alarm;  // RULE20
      alarm_out      <= rtc_alarm;  // RULE22
    end
  end

  // ----------------------------------------------------------------
  // Flash wake-up counter
  // ----------------------------------------------------------------
  assign flash_power_en = !(state_r == S_PDOWN || state_r == S_DPD);  // RULE14 RULE17
  // Ready drops with flash power, not one cycle after it
  assign flash_ready    = flash_power_en && fcnt_r == 9'(FLASH_WAKE_IRC);  // RULE17

  always_ff @(posedge clock) begin
    if (rst)
      fcnt_r <= 9'(FLASH_WAKE_IRC);
    else if (!flash_power_en)
      fcnt_r <= 9'h0;
    else if (state_r != S_IRCSTART && irc_tick && !flash_ready)
      fcnt_r <= fcnt_r + 9'h1;  // RULE18 RULE23
  end

  // ----------------------------------------------------------------
  // Oscillator and multiplier controls
  // ----------------------------------------------------------------
  assign irc_power_en  = !(state_r == S_PDOWN || state_r == S_DPD);  // RULE12 RULE17
  assign irc_out_en    = clocks_on || state_r == S_WAKE;  // RULE12
  assign regulator_en  = state_r != S_DPD;  // RULE19
  assign cpu_halt      = state_r != S_RUN;  // RULE11
  assign mult_power_en = mul_en_r;
  assign mult_bypass   = !mult_active;  // RULE5
  assign mult_m_val    = m_r;
  assign mult_n_val    = n_r;

  // ----------------------------------------------------------------
  // Processor, USB and peripheral clock dividers
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (rst) begin
      cdiv_cnt_r         <= 8'h0;
      udiv_cnt_r         <= 4'h0;
      processor_clock_en <= 1'b0;
      usb_clock_en       <= 1'b0;
    end else begin
      processor_clock_en <= 1'b0;
      usb_clock_en       <= 1'b0;
      if (base_tick && clocks_on) begin
        cdiv_cnt_r <= (cdiv_cnt_r >= cpudiv_r) ? 8'h0 : cdiv_cnt_r + 8'h1;
        udiv_cnt_r <= (udiv_cnt_r >= usbdiv_r) ? 4'h0 : udiv_cnt_r + 4'h1;
        processor_clock_en <= state_r == S_RUN && cdiv_cnt_r >= cpudiv_r;  // RULE11
        usb_clock_en       <= udiv_cnt_r >= usbdiv_r;
      end
    end
  end

  for (genvar g = 0; g < NUM_PERIPH; g++) begin : g_periph
    logic [2:0] pmask;
    assign pmask = 3'((4'h1 << pdiv_r[2*g +: 2]) - 4'h1);
    always_ff @(posedge clock) begin
      if (rst) begin
        pcnt_r[g]          <= 3'h0;
        periph_clock_en[g] <= 1'b0;
      end else begin
        periph_clock_en[g] <= 1'b0;
        if (base_tick && clocks_on) begin
          pcnt_r[g]          <= pcnt_r[g] + 3'h1;
          periph_clock_en[g] <= pgate_r[g] && (pcnt_r[g] & pmask) == 3'h0;  // RULE8 RULE11
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  crystal_holdoff_a: assert property (@(posedge clock) disable iff (rst)  // RULE10
    (src_sel_r == SRC_MAIN && !main_stable) |-> eff_src == SRC_IRC)
    else $error("crystal used before wake-up timer expired");

  mult_bypass_a: assert property (@(posedge clock) disable iff (rst)  // RULE7
    !(mul_en_r && mul_con_r && mult_lock) |-> base_tick == src_tick)
    else $error("processor clock not from multiplier input");

  sleep_entry_a: assert property (@(posedge clock) disable iff (rst)  // RULE13
    (state_r == S_RUN && wr_pend_r && waddr_r == A_PWRMODE && hwdata[3:0] == MODE_SLEEP)
    |=> state_r == S_SLEEP && !mul_en_r && !mul_con_r && cpudiv_r == 8'h0 && usbdiv_r == 4'h0)
    else $error("sleep entry left multiplier or dividers set");

  sleep_clocks_a: assert property (@(posedge clock) disable iff (rst)  // RULE12
    state_r == S_SLEEP ##1 state_r == S_SLEEP
    |-> !irc_out_en && irc_power_en && !processor_clock_en && periph_clock_en == '0)
    else $error("clocks running in sleep");

  wake_hold_a: assert property (@(posedge clock) disable iff (rst)  // RULE15
    (state_r == S_WAKE && !wake_done) |=> state_r == S_WAKE && cpu_halt)
    else $error("wake ended before count expired");

  wake_end_a: assert property (@(posedge clock) disable iff (rst)  // RULE15
    wake_done |-> $past(wcnt_r) <= wake_target ##1 (state_r == S_RUN && !cpu_halt))
    else $error("wake did not resume execution");

  pdown_power_a: assert property (@(posedge clock) disable iff (rst)  // RULE17
    state_r == S_PDOWN |-> !irc_power_en && !flash_power_en && !flash_ready && mult_bypass)
    else $error("power-down left oscillator or flash on");

  irc_start_a: assert property (@(posedge clock) disable iff (rst)  // RULE18
    $rose(state_r == S_IRCSTART) |-> (state_r == S_IRCSTART) [*8])
    else $error("RC start-up ended too early");

  flash_count_a: assert property (@(posedge clock) disable iff (rst)  // RULE23
    $rose(flash_ready) |-> $past(irc_tick) && $past(fcnt_r) == 9'(FLASH_WAKE_IRC - 1))
    else $error("flash ready without full count");

  dpd_stay_a: assert property (@(posedge clock) disable iff (rst)  // RULE20
    (state_r == S_DPD) |=> state_r == S_DPD && !regulator_en)
    else $error("deep power-down left without reset");

  idle_halt_a: assert property (@(posedge clock) disable iff (rst)  // RULE11
    state_r == S_IDLE ##1 state_r == S_IDLE |-> !processor_clock_en && cpu_halt)
    else $error("processor clocked in idle");

  mode_clear_a: assert property (@(posedge clock) disable iff (rst)  // RULE24
    state_r == S_RUN |-> mode_req_r == 4'h0)
    else $error("mode request not cleared after wake");

endmodule : ckpm_top

/* File: design/ckpm_pkg.sv */
// Constants, register map and state type of the clock and power-mode controller.
// Assumes a 10 MHz system clock; oscillator edges arrive as one-cycle tick strobes.
package ckpm_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS     = 100;
  localparam int IRC_START_NS      = 60000;
  localparam int IRC_START_CYC     = (IRC_START_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int IRC_FREQ_KHZ      = 4000;
  localparam int FLASH_WAKE_US     = 100;
  localparam int FLASH_WAKE_IRC    = FLASH_WAKE_US * IRC_FREQ_KHZ / 1000;
  localparam int SLEEP_WAKE_IRC    = 4;
  localparam int SLEEP_WAKE_MAIN   = 4096;
  localparam int MAIN_STABLE_TICKS = 4096;

  // ----------------------------------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] A_SRCSEL  = 8'h00;
  localparam logic [7:0] A_MULCFG  = 8'h04;
  localparam logic [7:0] A_MULCTL  = 8'h08;
  localparam logic [7:0] A_MULSTAT = 8'h0c;
  localparam logic [7:0] A_CPUDIV  = 8'h10;
  localparam logic [7:0] A_USBDIV  = 8'h14;
  localparam logic [7:0] A_PGATE   = 8'h18;
  localparam logic [7:0] A_PDIV    = 8'h1c;
  localparam logic [7:0] A_PWRMODE = 8'h20;
  localparam logic [7:0] A_OSCCTL  = 8'h24;
  localparam logic [7:0] A_BRAM    = 8'h40;
  localparam int         BRAM_WORDS = 16;

  // ----------------------------------------------------------------
  // Fields and reset values
  // ----------------------------------------------------------------
  localparam int         MUL_N_LSB    = 16;
  localparam int         ST_EN_BIT    = 24;
  localparam int         ST_CON_BIT   = 25;
  localparam int         ST_LOCK_BIT  = 26;
  localparam logic [1:0] SRC_IRC      = 2'h0;
  localparam logic [1:0] SRC_MAIN     = 2'h1;
  localparam logic [1:0] SRC_RTC      = 2'h2;
  localparam logic [3:0] MODE_IDLE    = 4'h1;
  localparam logic [3:0] MODE_SLEEP   = 4'h2;
  localparam logic [3:0] MODE_PDOWN   = 4'h4;
  localparam logic [3:0] MODE_DPD     = 4'h8;
  localparam logic [7:0] PGATE_RST    = 8'hff;
  localparam int         NUM_PERIPH   = 8;

  typedef enum {S_RUN, S_IDLE, S_SLEEP, S_PDOWN, S_DPD, S_IRCSTART, S_WAKE} ckpm_state_t;

endpackage : ckpm_pkg

/* File: dv/ckpm_osc_model.sv */
// Oscillator and multiplier model that feeds tick strobes to the controller.
// Assumes RC, crystal and multiplier outrun the 10 MHz clock and tick each cycle; the real-time oscillator ticks every fourth cycle.
`timescale 1ns/10ps
module ckpm_osc_model (
  input  wire logic clock,
  input  wire logic rst,
  input  wire logic irc_power_en,
  input  wire logic main_osc_en,
  input  wire logic mult_power_en,
  output logic      irc_tick,
  output logic      main_tick,
  output logic      rtc_tick,
  output logic      mult_tick,
  output logic      mult_lock
);
  logic [3:0] lock_cnt_r;
  logic [1:0] rtc_cnt_r;
  // ----------------------------------------------------------------
  // RC, crystal and multiplier run only while powered; the real-time oscillator always runs
  // ----------------------------------------------------------------
  assign irc_tick  = irc_power_en;
  assign main_tick = main_osc_en;
  assign mult_tick = mult_power_en;
  assign rtc_tick  = (rtc_cnt_r == 2'h3);
  assign mult_lock = (lock_cnt_r == 4'hf);
  always_ff @(posedge clock) begin
    if (rst) rtc_cnt_r <= 2'h0;
    else rtc_cnt_r <= rtc_cnt_r + 2'h1;
  end
  // Lock takes 15 cycles after power, lost one cycle after power goes off
  always_ff @(posedge clock) begin
    if (rst || !mult_power_en) lock_cnt_r <= 4'h0;
    else if (lock_cnt_r != 4'hf) lock_cnt_r <= lock_cnt_r + 4'h1;
  end
endmodule : ckpm_osc_model

/* File: dv/ckpm_top_test.sv */
// Directed bench for the clock and power-mode controller, driven over AHB-Lite.
// Assumes the oscillator model; deep power-down is left by a bench reset.
`timescale 1ns/10ps
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin failures++; \
  $display("Error at %0t: got %0h expected %0h", $time, g, e); end end
module ckpm_top_test import ckpm_pkg::*; ;
  logic        clock, rst, hsel, hwrite, hreadyout, hresp, any_irq, wake_irq, rtc_alarm;
  logic [31:0] haddr, hwdata, hrdata, v;
  logic [1:0]  htrans, multiplier_input_clock_sel;
  logic [2:0]  hsize = 3'h2;
  logic        irc_tick, main_tick, rtc_tick, mult_tick, mult_lock, processor_clock_en;
  logic        usb_clock_en, cpu_halt, irc_power_en, irc_out_en, main_osc_en, flash_power_en;
  logic        flash_ready, regulator_en, mult_power_en, mult_bypass, chip_reset_req, alarm_out;
  logic [7:0]  periph_clock_en, mult_n_val;
  logic [14:0] mult_m_val;
  int          failures, n_tests, np, n0, n2, nx, nu, t1, t2;
  ckpm_top i_ckpm_top (.clock, .rst, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready(hreadyout), .hrdata, .hreadyout, .hresp, .irc_tick, .main_tick, .rtc_tick,
    .mult_tick, .mult_lock, .any_irq, .wake_irq, .rtc_alarm, .multiplier_input_clock_sel,
    .processor_clock_en, .usb_clock_en, .periph_clock_en, .cpu_halt, .irc_power_en,
    .irc_out_en, .main_osc_en, .flash_power_en, .flash_ready, .regulator_en, .mult_power_en,
    .mult_bypass, .mult_m_val, .mult_n_val, .chip_reset_req, .alarm_out);
  ckpm_osc_model i_ckpm_osc_model (.clock, .rst, .irc_power_en, .main_osc_en, .mult_power_en,
    .irc_tick, .main_tick, .rtc_tick, .mult_tick, .mult_lock);
  // ----------------------------------------------------------------
  // Bus and observation tasks
  // ----------------------------------------------------------------
  task automatic bus(input logic [7:0] a, input logic wr, input logic [31:0] wd);
    @(posedge clock);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    hwrite <= wr;
    htrans <= 2'h2;
    do @(posedge clock); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= wd;
    do @(posedge clock); while (hreadyout !== 1'b1);
    v = hrdata;
  endtask : bus
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(a, 1'b1, d);
    @(negedge clock);
  endtask : wr
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    bus(a, 1'b0, 32'h0);
    `CHK(v, e)
  endtask : rd_chk
  task automatic watch(input int n);
    {np, n0, n2, nx, nu} = '0;
    repeat (n) begin
      @(negedge clock);
      np += processor_clock_en;
      nu += usb_clock_en;
      n0 += periph_clock_en[0];
      n2 += periph_clock_en[2];
      nx += int'((periph_clock_en & 8'hfa) != 8'h0);
    end
  endtask : watch
  // Cycles until the processor runs (t1) and flash is ready (t2)
  task automatic wake();
    @(posedge clock);
    wake_irq <= 1'b1;
    t1 = 0;
    t2 = 0;
    while ((cpu_halt !== 1'b0 || flash_ready !== 1'b1) && t2 < 6000) begin
      @(negedge clock);
      t2++;
      if (cpu_halt === 1'b1) t1 = t2;
    end
    @(posedge clock);
    wake_irq <= 1'b0;
  endtask : wake
  task automatic tally_and_finish();
    $display("Comparisons %0d, mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : tally_and_finish
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end
  initial begin
    #3000000;
    failures++;
    tally_and_finish();
  end
  // ----------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------
  initial begin
    {hsel, hwrite, htrans, haddr, hwdata, any_irq, wake_irq, rtc_alarm} = '0;
    rst = 1'b1;
    repeat (12) @(posedge clock);
    rst <= 1'b0;
    rd_chk(A_SRCSEL, 32'h0);
    rd_chk(A_PGATE, 32'hff);
    rd_chk(A_OSCCTL, 32'h4);
    rd_chk(8'h80, 32'h0);
    `CHK(mult_bypass, 1'b1)
    wr(A_PDIV, 32'h2);
    wr(A_PGATE, 32'h5);
    watch(40);
    `CHK(n0 inside {[9:11]}, 1'b1)
    `CHK(n2 inside {[39:40]}, 1'b1)
    `CHK(nx, 0)
    `CHK(np inside {[39:40]}, 1'b1)
    wr(A_SRCSEL, 32'h2);
    `CHK(multiplier_input_clock_sel, SRC_RTC)
    wr(A_SRCSEL, 32'h3);
    `CHK(multiplier_input_clock_sel, SRC_RTC)
    wr(A_SRCSEL, 32'h1);
    `CHK(multiplier_input_clock_sel, SRC_IRC)
    wr(A_OSCCTL, 32'h1);
    repeat (4100) @(posedge clock);
    rd_chk(A_OSCCTL, 32'h7);
    `CHK(multiplier_input_clock_sel, SRC_MAIN)
    wr(A_MULCFG, 32'h00ff7fff);
    `CHK(mult_m_val, 15'h7fff)
    `CHK(mult_n_val, 8'hff)
    wr(A_MULCTL, 32'h1);
    repeat (20) @(posedge clock);
    rd_chk(A_MULSTAT, 32'h05ff7fff);
    wr(A_MULCTL, 32'h3);
    rd_chk(A_MULSTAT, 32'h07ff7fff);
    `CHK(mult_bypass, 1'b0)
    wr(A_CPUDIV, 32'h3);
    wr(A_USBDIV, 32'h2);
    wr(A_BRAM, 32'ha5a55a5a);
    watch(40);
    `CHK(np inside {[9:11]}, 1'b1)
    `CHK(nu inside {[13:14]}, 1'b1)
    wr(A_PWRMODE, {28'h0, MODE_SLEEP});
    `CHK({cpu_halt, irc_out_en, irc_power_en, main_osc_en}, 4'b1010)
    `CHK({flash_power_en, mult_power_en}, 2'b10)
    watch(10);
    `CHK(np + n2 + nu, 0)
    rd_chk(A_PWRMODE, 32'h2);
    any_irq <= 1'b1;
    repeat (3) @(negedge clock);
    `CHK(cpu_halt, 1'b1)
    @(posedge clock) any_irq <= 1'b0;
    wake();
    `CHK(t1 inside {[4096:4100]}, 1'b1)
    rd_chk(A_MULSTAT, 32'h00ff7fff);
    rd_chk(A_CPUDIV, 32'h0);
    rd_chk(A_USBDIV, 32'h0);
    rd_chk(A_PWRMODE, 32'h0);
    wr(A_PWRMODE, {28'h0, MODE_IDLE});
    watch(20);
    `CHK(np, 0)
    `CHK(n2 inside {[19:20]}, 1'b1)
    `CHK(nu inside {[19:20]}, 1'b1)
    @(posedge clock) any_irq <= 1'b1;
    repeat (2) @(negedge clock);
    `CHK(cpu_halt, 1'b0)
    @(posedge clock) any_irq <= 1'b0;
    wr(A_MULCTL, 32'h1);
    wr(A_PWRMODE, {28'h0, MODE_PDOWN});
    `CHK({irc_power_en, flash_power_en, flash_ready}, 3'b000)
    `CHK({mult_bypass, mult_power_en}, 2'b10)
    `CHK(multiplier_input_clock_sel, SRC_IRC)
    wake();
    `CHK(t1 inside {[600:612]}, 1'b1)
    `CHK(t2 inside {[995:1012]}, 1'b1)
    wr(A_PWRMODE, {28'h0, MODE_DPD});
    `CHK({regulator_en, chip_reset_req}, 2'b00)
    wake();
    `CHK(cpu_halt, 1'b1)
    @(posedge clock) rtc_alarm <= 1'b1;
    repeat (3) @(negedge clock);
    `CHK({alarm_out, chip_reset_req}, 2'b11)
    @(posedge clock);
    rtc_alarm <= 1'b0;
    rst <= 1'b1;
    repeat (12) @(posedge clock);
    rst <= 1'b0;
    rd_chk(A_BRAM, 32'ha5a55a5a);
    rd_chk(A_SRCSEL, 32'h0);
    `CHK(regulator_en, 1'b1)
    tally_and_finish();
  end
endmodule : ckpm_top_test
